// File: src/converter_config_register_bank.sv
// Serial-port configuration and status bank of a dual modulator
`timescale 1ns/1ps
`include "converter_cfg_defs.svh"
module converter_config_register_bank #(
    parameter logic [7:0] PART_ID    = 8'h5A, // Arbitrary neutral value
    parameter logic [1:0] GRADE_CODE = 2'h0
) (
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    input  wire logic       sclk_i,
    input  wire logic       port_select_n_i,
    input  wire logic       sdio_i,
    output logic            sdio_o,
    output logic            sdio_oe_o,
    input  wire logic       loop_lock_i,
    output logic [1:0]      power_state_a_o,
    output logic [1:0]      power_state_b_o,
    output logic            chan_a_enabled_o,
    output logic            chan_b_enabled_o,
    output logic            reference_on_o,
    output logic            multiplier_loop_on_o,
    output logic            auto_band_select_o,
    output logic [5:0]      loop_multiplier_o,
    output logic            driver_standard_o,
    output logic            output_disable_o,
    output logic            data_output_enable_o,
    output logic [1:0]      output_termination_select_o,
    output logic            term_200_o,
    output logic            term_100_o,
    output logic            data_clock_invert_o,
    output logic            external_ref_select_o,
    output logic            overrange_auto_clear_o,
    output logic            overrange_indicator_one_o,
    output logic            overrange_indicator_two_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and serial clock edges

    logic        sclk_s;
    logic        csb_s;
    logic        sdio_s;
    logic        lock_s;
    logic        sclk_prev_q;
    wire         sclk_rise = sclk_s & ~sclk_prev_q;
    wire         sclk_fall = ~sclk_s & sclk_prev_q;

    pin_sync #(.WIDTH(4), .RESET_VALUE(4'h2)) u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .async_i   ({loop_lock_i, sdio_i, port_select_n_i, sclk_i}),
        .sync_o    ({lock_s, sdio_s, csb_s, sclk_s})
    );

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sclk_prev_q <= 1'h0;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame state

    converter_cfg_pkg::port_state_type state_q;
    converter_cfg_pkg::port_state_type state_d;
    logic [3:0]  bit_cnt_q;
    logic [15:0] instr_q;
    logic [7:0]  byte_q;
    logic [12:0] addr_q;
    logic        read_q;
    logic        stream_q;
    logic [1:0]  bytes_left_q;
    logic        lsb_first_q;

    wire in_instr = (state_q == converter_cfg_pkg::PORT_INSTR);
    wire in_data  = (state_q == converter_cfg_pkg::PORT_DATA);

    // Assembly follows the current bit order
    wire [15:0] instr_shift = lsb_first_q ? {sdio_s, instr_q[15:1]}
                                          : {instr_q[14:0], sdio_s};
    wire [7:0]  byte_shift  = lsb_first_q ? {sdio_s, byte_q[7:1]}
                                          : {byte_q[6:0], sdio_s};

    wire instr_done = sclk_rise & in_instr
                    & (bit_cnt_q == `INSTR_LAST_BIT);
    wire byte_done  = sclk_rise & in_data
                    & (bit_cnt_q[2:0] == `BYTE_LAST_BIT);
    wire last_byte  = ~stream_q & (bytes_left_q == 2'h0);
    wire [12:0] addr_step = lsb_first_q ? addr_q + 13'h0001
                                        : addr_q - 13'h0001;

    always_comb begin
        state_d = state_q;
        case (state_q)
            converter_cfg_pkg::PORT_IDLE: begin
                state_d = converter_cfg_pkg::PORT_INSTR;
            end
            converter_cfg_pkg::PORT_INSTR: begin
                if (instr_done) begin
                    state_d = converter_cfg_pkg::PORT_DATA;
                end
            end
            converter_cfg_pkg::PORT_DATA: begin
                if (byte_done && last_byte) begin
                    state_d = converter_cfg_pkg::PORT_DONE;
                end
            end
            converter_cfg_pkg::PORT_DONE: begin
                state_d = converter_cfg_pkg::PORT_DONE;
            end
            default: begin
                state_d = converter_cfg_pkg::PORT_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i || csb_s) begin
            state_q <= converter_cfg_pkg::PORT_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Bit count: 16 in the instruction, 8 in each data word
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || csb_s || instr_done || byte_done) begin
            bit_cnt_q <= 4'h0;
        end else if (sclk_rise && (in_instr || in_data)) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            instr_q <= 16'h0000;
            byte_q  <= 8'h00;
        end else if (sclk_rise && in_instr) begin
            instr_q <= instr_shift;
        end else if (sclk_rise && in_data) begin
            byte_q  <= byte_shift;
        end
    end

    // Instruction fields: direction, length, start address
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            read_q       <= 1'h0;
            stream_q     <= 1'h0;
            bytes_left_q <= 2'h0;
            addr_q       <= 13'h0000;
        end else if (instr_done) begin
            read_q       <= instr_shift[`INSTR_READ_BIT];
            stream_q     <= instr_shift[`INSTR_LEN_HI:`INSTR_LEN_LO]
                            == `LEN_STREAM;
            bytes_left_q <= instr_shift[`INSTR_LEN_HI:`INSTR_LEN_LO];
            addr_q       <= instr_shift[12:0];
        end else if (byte_done) begin
            bytes_left_q <= bytes_left_q - 2'h1;
            addr_q       <= addr_step;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write decode

    wire [7:0] wdata    = byte_shift;
    wire wr_byte        = byte_done & ~read_q;
    wire wr_port        = wr_byte & (addr_q == `OFS_PORT_CONFIG);
    wire wr_channel     = wr_byte & (addr_q == `OFS_CHANNEL);
    wire wr_power       = wr_byte & (addr_q == `OFS_POWER);
    wire wr_loop_on     = wr_byte & (addr_q == `OFS_LOOP_ENABLE);
    wire wr_loop_ctl    = wr_byte & (addr_q == `OFS_LOOP_CONTROL);
    wire wr_out_mode    = wr_byte & (addr_q == `OFS_OUTPUT_MODE);
    wire wr_out_adjust  = wr_byte & (addr_q == `OFS_OUTPUT_ADJUST);
    wire wr_out_clock   = wr_byte & (addr_q == `OFS_OUTPUT_CLOCK);
    wire wr_reference   = wr_byte & (addr_q == `OFS_REFERENCE);
    wire wr_overrange   = wr_byte & (addr_q == `OFS_OVERRANGE);
    wire soft_clear     = wr_port & (wdata[`POS_SOFT_HI]
                                   | wdata[`POS_SOFT_LO]);
    wire order_bit      = wdata[`POS_ORDER_HI] | wdata[`POS_ORDER_LO];

    logic [1:0] channel_q;
    logic [6:0] loop_ctl_q;
    logic [1:0] out_mode_q;
    logic [2:0] overrange_q;

    wire wr_power_a = wr_power & channel_q[0];
    wire wr_power_b = wr_power & channel_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Register fields

    // Port config and loop registers survive a soft reset
    field_reg #(.WIDTH(1), .RESET_VALUE(`RST_BIT_ORDER)) u_bit_order (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .soft_clear_i(1'h0),
        .write_i(wr_port), .data_i(order_bit),
        .value_o(lsb_first_q));

    field_reg #(.WIDTH(1), .RESET_VALUE(`RST_LOOP_ON)) u_loop_on (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .soft_clear_i(1'h0),
        .write_i(wr_loop_on), .data_i(wdata[`POS_LOOP_ON]),
        .value_o(multiplier_loop_on_o));

    field_reg #(.WIDTH(7), .RESET_VALUE(`RST_LOOP_CONTROL)) u_loop_ctl (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .soft_clear_i(1'h0),
        .write_i(wr_loop_ctl), .data_i(wdata[6:0]),
        .value_o(loop_ctl_q));

    field_reg #(.WIDTH(2), .RESET_VALUE(`RST_CHANNEL)) u_channel (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .soft_clear_i(soft_clear),
        .write_i(wr_channel), .data_i(wdata[1:0]),
        .value_o(channel_q));

    field_reg #(.WIDTH(2), .RESET_VALUE(`RST_POWER)) u_power_a (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .soft_clear_i(soft_clear),
        .write_i(wr_power_a), .data_i(wdata[1:0]),
        .value_o(power_state_a_o));

    field_reg #(.WIDTH(2), .RESET_VALUE(`RST_POWER)) u_power_b (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .soft_clear_i(soft_clear),
        .write_i(wr_power_b), .data_i(wdata[1:0]),
        .value_o(power_state_b_o));

    field_reg #(.WIDTH(2), .RESET_VALUE(`RST_OUTPUT_MODE)) u_out_mode (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .soft_clear_i(soft_clear),
        .write_i(wr_out_mode),
        .data_i({wdata[`POS_DRIVER_STD], wdata[`POS_OUT_DISABLE]}),
        .value_o(out_mode_q));

    field_reg #(.WIDTH(2), .RESET_VALUE(`RST_TERM)) u_term (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .soft_clear_i(soft_clear),
        .write_i(wr_out_adjust),
        .data_i(wdata[`POS_TERM_LO+1:`POS_TERM_LO]),
        .value_o(output_termination_select_o));

    field_reg #(.WIDTH(1), .RESET_VALUE(`RST_CLOCK_INVERT)) u_clk_inv (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .soft_clear_i(soft_clear),
        .write_i(wr_out_clock), .data_i(wdata[`POS_CLOCK_INVERT]),
        .value_o(data_clock_invert_o));

    field_reg #(.WIDTH(1), .RESET_VALUE(`RST_EXT_REF)) u_ext_ref (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .soft_clear_i(soft_clear),
        .write_i(wr_reference), .data_i(wdata[`POS_EXT_REF]),
        .value_o(external_ref_select_o));

    field_reg #(.WIDTH(3), .RESET_VALUE(`RST_OVERRANGE)) u_overrange (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .soft_clear_i(soft_clear),
        .write_i(wr_overrange), .data_i(wdata[7:5]),
        .value_o(overrange_q));

    assign auto_band_select_o        = loop_ctl_q[6];
    assign loop_multiplier_o         = loop_ctl_q[5:0];
    assign driver_standard_o         = out_mode_q[1];
    assign output_disable_o          = out_mode_q[0];
    assign overrange_auto_clear_o    = overrange_q[2];
    assign overrange_indicator_one_o = overrange_q[1];
    assign overrange_indicator_two_o = overrange_q[0];

    ////////////////////////////////////////////////////////////////////////
    // Decoded control outputs

    wire a_sleep = power_state_a_o == converter_cfg_pkg::POWER_SLEEP;
    wire b_sleep = power_state_b_o == converter_cfg_pkg::POWER_SLEEP;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            chan_a_enabled_o     <= 1'h1;
            chan_b_enabled_o     <= 1'h1;
            reference_on_o       <= 1'h1;
            data_output_enable_o <= 1'h1;
            term_200_o           <= 1'h0;
            term_100_o           <= 1'h0;
        end else begin
            chan_a_enabled_o     <= power_state_a_o ==
                                    converter_cfg_pkg::POWER_NORMAL;
            chan_b_enabled_o     <= power_state_b_o ==
                                    converter_cfg_pkg::POWER_NORMAL;
            // Standby keeps the reference; only sleep on both channels stops it
            reference_on_o       <= ~(a_sleep & b_sleep);
            data_output_enable_o <= ~out_mode_q[0];
            term_200_o           <= output_termination_select_o
                                    == converter_cfg_pkg::TERM_200;
            term_100_o           <= output_termination_select_o[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux

    wire [7:0] rd_port  = {1'h0, lsb_first_q, 1'h0, 1'h1,
                           1'h1, 1'h0, lsb_first_q, 1'h0};
    wire [7:0] rd_grade = {2'h0, GRADE_CODE, 4'h0};
    wire [1:0] rd_power = channel_q[0] ? power_state_a_o
                                       : power_state_b_o;
    wire [7:0] rd_loop  = {lock_s, loop_ctl_q};

    wire [7:0] rd_data =
        (addr_q == `OFS_PORT_CONFIG)   ? rd_port :
        (addr_q == `OFS_PART_ID)       ? PART_ID :
        (addr_q == `OFS_GRADE)         ? rd_grade :
        (addr_q == `OFS_CHANNEL)       ? {6'h00, channel_q} :
        (addr_q == `OFS_POWER)         ? {6'h00, rd_power} :
        (addr_q == `OFS_LOOP_ENABLE)   ? {5'h00, multiplier_loop_on_o,
                                          2'h0} :
        (addr_q == `OFS_LOOP_CONTROL)  ? rd_loop :
        (addr_q == `OFS_OUTPUT_MODE)   ? {out_mode_q[1], 2'h0,
                                          out_mode_q[0], 4'h0} :
        (addr_q == `OFS_OUTPUT_ADJUST) ? {2'h0,
                                          output_termination_select_o,
                                          4'h0} :
        (addr_q == `OFS_OUTPUT_CLOCK)  ? {data_clock_invert_o, 7'h00} :
        (addr_q == `OFS_REFERENCE)     ? {1'h0, external_ref_select_o,
                                          6'h00} :
        (addr_q == `OFS_OVERRANGE)     ? {overrange_q, 5'h00} :
                                         8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Readback driver, launched on falling serial clock

    wire [2:0] rd_index = lsb_first_q ? bit_cnt_q[2:0]
                                      : `BYTE_LAST_BIT - bit_cnt_q[2:0];
    wire       driving  = in_data & read_q;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i || csb_s) begin
            sdio_o    <= 1'h0;
            sdio_oe_o <= 1'h0;
        end else if (sclk_fall) begin
            sdio_o    <= driving & rd_data[rd_index];
            sdio_oe_o <= driving;
        end
    end

endmodule // converter_config_register_bank

// File: src/converter_cfg_defs.svh
// Offsets, field positions, reset values and frame counts of the bank
`ifndef CONVERTER_CFG_DEFS_SVH
`define CONVERTER_CFG_DEFS_SVH

// Register offsets
`define OFS_PORT_CONFIG    13'h0000
`define OFS_PART_ID        13'h0001
`define OFS_GRADE          13'h0002
`define OFS_CHANNEL        13'h0005
`define OFS_POWER          13'h0008
`define OFS_LOOP_ENABLE    13'h0009
`define OFS_LOOP_CONTROL   13'h000A
`define OFS_OUTPUT_MODE    13'h0014
`define OFS_OUTPUT_ADJUST  13'h0015
`define OFS_OUTPUT_CLOCK   13'h0016
`define OFS_REFERENCE      13'h0018
`define OFS_OVERRANGE      13'h0111

// Field positions
`define POS_ORDER_HI       6
`define POS_ORDER_LO       1
`define POS_SOFT_HI        5
`define POS_SOFT_LO        2
`define POS_LOOP_ON        2
`define POS_LOCK           7
`define POS_DRIVER_STD     7
`define POS_OUT_DISABLE    4
`define POS_TERM_LO        4
`define POS_CLOCK_INVERT   7
`define POS_EXT_REF        6
`define POS_AUTO_CLEAR     7
`define POS_GRADE_LO       4

// Reset values
`define RST_BIT_ORDER      1'h0
`define RST_CHANNEL        2'h0
`define RST_POWER          2'h0
`define RST_LOOP_ON        1'h0
`define RST_LOOP_CONTROL   7'h00
`define RST_OUTPUT_MODE    2'h0
`define RST_TERM           2'h0
`define RST_CLOCK_INVERT   1'h0
`define RST_EXT_REF        1'h0
`define RST_OVERRANGE      3'h0

// Frame counts
`define INSTR_LAST_BIT     4'hF
`define BYTE_LAST_BIT      3'h7
`define LEN_STREAM         2'h3
`define INSTR_READ_BIT     15
`define INSTR_LEN_HI       14
`define INSTR_LEN_LO       13

`endif

// File: src/converter_cfg_pkg.sv
// Types shared by the configuration bank
package converter_cfg_pkg;

    typedef enum logic [1:0] {
        PORT_IDLE  = 2'h0,
        PORT_INSTR = 2'h1,
        PORT_DATA  = 2'h3,
        PORT_DONE  = 2'h2
    } port_state_type;

    typedef enum logic [1:0] {
        POWER_NORMAL     = 2'h0,
        POWER_LOCAL_DOWN = 2'h1,
        POWER_STANDBY    = 2'h2,
        POWER_SLEEP      = 2'h3
    } power_state_type;

    typedef enum logic [1:0] {
        TERM_NONE    = 2'h0,
        TERM_200     = 2'h1,
        TERM_100     = 2'h2,
        TERM_100_ALT = 2'h3
    } termination_type;

endpackage

// File: src/pin_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
    parameter int                 WIDTH       = 1,
    parameter logic [WIDTH-1:0]   RESET_VALUE = '0
) (
    input  wire logic             sys_clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            meta_q <= RESET_VALUE;
            sync_o <= RESET_VALUE;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule // pin_sync

// File: src/field_reg.sv
// One writable register field with reset and soft default
`timescale 1ns/1ps
module field_reg #(
    parameter int                 WIDTH       = 1,
    parameter logic [WIDTH-1:0]   RESET_VALUE = '0
) (
    input  wire logic             sys_clk_i,
    input  wire logic             reset_i,
    input  wire logic             soft_clear_i,
    input  wire logic             write_i,
    input  wire logic [WIDTH-1:0] data_i,
    output logic      [WIDTH-1:0] value_o
);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || soft_clear_i) begin
            value_o <= RESET_VALUE;
        end else if (write_i) begin
            value_o <= data_i;
        end
    end
endmodule // field_reg

// File: bench/converter_cfg_props.sv
// Port-level assertions of the configuration bank
`timescale 1ns/1ps
module converter_cfg_props (
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    input  wire logic       port_select_n_i,
    input  wire logic       sdio_o,
    input  wire logic       sdio_oe_o,
    input  wire logic [1:0] power_state_a_o,
    input  wire logic [1:0] power_state_b_o,
    input  wire logic       chan_a_enabled_o,
    input  wire logic       chan_b_enabled_o,
    input  wire logic       reference_on_o,
    input  wire logic       output_disable_o,
    input  wire logic       data_output_enable_o,
    input  wire logic [1:0] output_termination_select_o,
    input  wire logic       term_200_o,
    input  wire logic       term_100_o,
    input  wire logic       driver_standard_o,
    input  wire logic       external_ref_select_o,
    input  wire logic       data_clock_invert_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    dout_follow_a: assert property (!$past(reset_i) |->
        data_output_enable_o == !$past(output_disable_o)) else $error("dout");
    chan_a_on_a: assert property (!$past(reset_i) |->
        chan_a_enabled_o == ($past(power_state_a_o) == 2'h0)) else $error("a");
    chan_b_on_a: assert property (!$past(reset_i) |->
        chan_b_enabled_o == ($past(power_state_b_o) == 2'h0)) else $error("b");
    ref_sleep_a: assert property (!$past(reset_i) |-> reference_on_o ==
        !($past(power_state_a_o) == 2'h3 && $past(power_state_b_o) == 2'h3))
        else $error("reference");
    term_two_a: assert property (!$past(reset_i) |->
        term_200_o == ($past(output_termination_select_o) == 2'h1))
        else $error("term 200");
    term_one_a: assert property (!$past(reset_i) |->
        term_100_o == $past(output_termination_select_o[1]))
        else $error("term 100");
    oe_idle_a: assert property (port_select_n_i [*6] |-> !sdio_oe_o)
        else $error("drive outside frame");
    sdio_quiet_a: assert property (!sdio_oe_o |-> !sdio_o)
        else $error("data while released");
    cfg_stable_a: assert property (port_select_n_i [*8] |->
        $stable({driver_standard_o, external_ref_select_o, data_clock_invert_o,
        output_disable_o})) else $error("field moved outside frame");
endmodule // converter_cfg_props

bind converter_config_register_bank converter_cfg_props chk_i (
    .sys_clk_i, .reset_i, .port_select_n_i, .sdio_o, .sdio_oe_o,
    .power_state_a_o, .power_state_b_o, .chan_a_enabled_o, .chan_b_enabled_o,
    .reference_on_o, .output_disable_o, .data_output_enable_o,
    .output_termination_select_o, .term_200_o, .term_100_o,
    .driver_standard_o, .external_ref_select_o, .data_clock_invert_o);

// File: bench/host_model.sv
// Host controller model driving the three-wire serial port
`timescale 1ns/1ps
module host_model (
    input  wire logic sys_clk_i,
    input  wire logic dev_data_i,
    input  wire logic dev_oe_i,
    output logic      sclk_o,
    output logic      port_select_n_o,
    output logic      line_o
);
    logic drive_q = 1'h0;
    logic lsb_first = 1'h0;
    assign line_o = dev_oe_i ? dev_data_i : drive_q;
    initial begin
        sclk_o = 1'h0;
        port_select_n_o = 1'h1;
    end
    task automatic half();
        repeat (8) @(negedge sys_clk_i);
    endtask
    // Released line toggles so stale data is never read
    task automatic bit_x(input logic b, input logic rel, output logic r);
        drive_q = rel ? ~drive_q : b;
        half();
        sclk_o = 1'h1;
        r = line_o;
        half();
        sclk_o = 1'h0;
    endtask
    // Sends n data words; low word goes first in LSB-first mode
    task automatic xfer(input logic [15:0] ins, input logic [15:0] wd,
                        input int n, output logic [7:0] rd);
        logic r;
        port_select_n_o = 1'h0;
        for (int i = 0; i < 16; i++)
            bit_x(ins[lsb_first ? i : 15 - i], 1'h0, r);
        for (int i = 0; i < 8 * n; i++) begin
            bit_x(wd[lsb_first ? i : 8 * n - 1 - i], ins[15], r);
            rd[lsb_first ? i % 8 : 7 - i % 8] = r;
        end
        half();
        port_select_n_o = 1'h1;
        half();
    endtask
endmodule // host_model

// File: bench/converter_config_register_bank_tb.sv
// Self-checking bench of the configuration bank
`timescale 1ns/1ps
module converter_config_register_bank_tb;
    logic       clk = 1'h0;
    logic       rst = 1'h1;
    logic       lock = 1'h0;
    logic       sclk, psn, line, sdo, soe, ea, eb, ref_on, lon, abs, dstd;
    logic       odis, doe, t200, t100, dci, ext, oac, oi1, oi2;
    logic [1:0] pa, pb, tsel;
    logic [5:0] mult;
    logic [7:0] rd;
    int         failures = 0;
    int         total_checks = 0;
    int         cycles = 0;

    // Part code below is arbitrary
    converter_config_register_bank #(.PART_ID(8'h3C), .GRADE_CODE(2'h2)) DUT (
        .sys_clk_i(clk), .reset_i(rst), .sclk_i(sclk), .port_select_n_i(psn),
        .sdio_i(line), .sdio_o(sdo), .sdio_oe_o(soe), .loop_lock_i(lock),
        .power_state_a_o(pa), .power_state_b_o(pb), .chan_a_enabled_o(ea),
        .chan_b_enabled_o(eb), .reference_on_o(ref_on),
        .multiplier_loop_on_o(lon), .auto_band_select_o(abs),
        .loop_multiplier_o(mult), .driver_standard_o(dstd),
        .output_disable_o(odis), .data_output_enable_o(doe),
        .output_termination_select_o(tsel), .term_200_o(t200),
        .term_100_o(t100), .data_clock_invert_o(dci),
        .external_ref_select_o(ext), .overrange_auto_clear_o(oac),
        .overrange_indicator_one_o(oi1), .overrange_indicator_two_o(oi2));
    host_model host (.sys_clk_i(clk), .dev_data_i(sdo), .dev_oe_i(soe),
        .sclk_o(sclk), .port_select_n_o(psn), .line_o(line));

    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        host.xfer({3'h0, a}, {8'h00, d}, 1, rd);
    endtask
    task automatic rdc(input logic [12:0] a, input logic [7:0] e);
        host.xfer({3'h4, a}, 16'h0000, 1, rd);
        chk(rd, e);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({4'h0, doe, ea, eb, ref_on}, 8'h0F);
        chk({pa, pb, tsel, t200, t100}, 8'h00);
        rdc(13'h000, 8'h18);
        rdc(13'h001, 8'h3C);
        rdc(13'h002, 8'h20);
        rdc(13'h003, 8'h00);
        rdc(13'h00A, 8'h00);
        rdc(13'h014, 8'h00);
        rdc(13'h018, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_fields();
        logic [12:0] ad [7] = '{13'h009, 13'h00A, 13'h014, 13'h015, 13'h016,
                                13'h018, 13'h111};
        logic [7:0]  wd [7] = '{8'h04, 8'hFF, 8'h90, 8'h10, 8'h80, 8'h40,
                                8'hE0};
        logic [7:0]  te [4] = '{8'h00, 8'h02, 8'h01, 8'h01};
        for (int i = 0; i < 7; i++) begin
            wr(ad[i], wd[i]);
            rdc(ad[i], (i == 1) ? 8'h7F : wd[i]);
        end
        chk({lon, abs, mult}, 8'hFF);
        chk({dstd, odis, doe, t200, t100, dci, ext, 1'h0}, 8'hD6);
        chk({5'h0, oac, oi1, oi2}, 8'h07);
        for (int c = 0; c < 4; c++) begin
            wr(13'h015, {2'h0, c[1:0], 4'h0});
            chk({6'h0, t200, t100}, te[c]);
        end
        @(negedge clk);
        lock = 1'h1;
        rdc(13'h00A, 8'hFF);
        wr(13'h001, 8'h00);
        rdc(13'h001, 8'h3C);
        $display("test fields done");
    endtask
    task automatic t_chan();
        logic [1:0] cs [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
        logic [1:0] ps [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
        logic [7:0] ex [4] = '{8'hA4, 8'h86, 8'h0F, 8'hE0};
        for (int i = 0; i < 4; i++) begin
            wr(13'h005, {6'h0, cs[i]});
            wr(13'h008, {6'h0, ps[i]});
            chk({ref_on, ea, eb, 1'h0, pa, pb}, ex[i]);
            rdc(13'h008, {6'h0, ps[i]});
        end
        $display("test channels done");
    endtask
    task automatic t_soft();
        logic [12:0] ad [9] = '{13'h005, 13'h008, 13'h014, 13'h015, 13'h016,
                                13'h018, 13'h111, 13'h009, 13'h00A};
        logic [7:0]  ex [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                8'h00, 8'h04, 8'hFF};
        wr(13'h008, 8'h02);
        wr(13'h000, 8'h24);
        chk({pa, pb, 4'h0}, 8'h00);
        for (int i = 0; i < 9; i++)
            rdc(ad[i], ex[i]);
        rdc(13'h000, 8'h18);
        $display("test soft reset done");
    endtask
    task automatic t_order();
        wr(13'h000, 8'h40);
        host.lsb_first = 1'h1;
        wr(13'h018, 8'h40);
        chk({7'h0, ext}, 8'h01);
        wr(13'h000, 8'h00);
        host.lsb_first = 1'h0;
        wr(13'h000, 8'h02);
        host.lsb_first = 1'h1;
        rdc(13'h018, 8'h40);
        wr(13'h000, 8'h00);
        host.lsb_first = 1'h0;
        rdc(13'h000, 8'h18);
        $display("test bit order done");
    endtask
    // Two-word write, MSB first: address steps down from 0x016 to 0x015
    task automatic t_burst();
        host.xfer({3'h1, 13'h016}, 16'h8020, 2, rd);
        chk({dci, t100, 4'h0, tsel}, 8'hC2);
        $display("test burst done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'h0;
        repeat (6) @(negedge clk);
        t_reset();
        t_fields();
        t_chan();
        t_soft();
        t_order();
        t_burst();
        close_out();
    end
endmodule // converter_config_register_bank_tb
